// [src/adr_pkg.sv]
// Purpose: Shared constants, types and helpers for the dual-line serial readout
// Assumes: 18-bit results, eight channels, one system clock
// Notes: Pin vector indices describe the order of the synchroniser bundle
package adr_pkg;
    localparam int RES_W = 18;
    localparam int CH_N = 8;
    localparam int OSR_W = 3;
    localparam int OSR_MAX = 6;
    localparam int ACC_W = RES_W + OSR_MAX;
    localparam int FIFO_D = 8;
    localparam int SYNC_W = 9;
    localparam int PIN_CS = 8;
    localparam int PIN_SCLK = 7;
    localparam int PIN_CVA = 6;
    localparam int PIN_CVB = 5;
    localparam int PIN_IFS = 4;
    localparam int PIN_BSS = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h100;
    localparam logic [4:0] BIT_FIRST = 5'h00;
    localparam logic [4:0] BIT_LAST = 5'h11;
    localparam logic [2:0] GRP_FIRST = 3'h0;
    localparam logic [2:0] B_OFFSET = 3'h4;
    localparam logic [2:0] CH_LAST = 3'h7;
    localparam logic [OSR_W-1:0] OSR_RST = 3'h0;
    localparam logic [RES_W-1:0] RES_RST = 18'h0_0000;
    localparam logic [9:0] BUSY_CNT_RST = 10'h000;

    typedef enum logic [1:0] {
        ADR_IDLE = 2'b00,
        ADR_RUN = 2'b01,
        ADR_LOAD = 2'b10
    } adr_conv_t;

    function automatic logic bit_of(input logic [RES_W-1:0] w, input logic [4:0] i);
        return w[BIT_LAST - i];
    endfunction : bit_of

    function automatic logic [RES_W-1:0] avg_of(input logic signed [ACC_W-1:0] a, input logic [OSR_W-1:0] s);
        logic signed [ACC_W-1:0] q;
        q = a >>> s;
        return q[RES_W-1:0];
    endfunction : avg_of
endpackage : adr_pkg

// [src/adr_serial_readout.sv]
// Purpose: Serial readout port with oversampling average and result bank
// Assumes: Pins are asynchronous to clk_sys; shift clock much slower than clk_sys
// Notes: Raw samples arrive channel 0..7 per pass through an 8-word FIFO
// Overview of operation
// - Serial mode when select high, byte-select low
// - Chip select high: outputs tri-state, clock ignored
// - Select falling edge drives MSB on both lines
// - Seventeen further bits on rising edges, 18 cycles
// - Line A channels 1-8, line B 5-8 then 1-4
// - Flag high with channel 1, low at 18th fall
// - Flag also marks channel 5 on line B
// - Read during busy returns previous sample
// - Read during conversion works in every setting
// - Host keeps select high before busy falls
// - Ratio pins latched on busy falling edge
// - Busy lengthens as the ratio grows from 0 to 6; ratio 7 gives a single pass
// - Oversampled results pass an averaging filter
// - Result bank loaded as busy falls
`timescale 1ns/1ps

module adr_fifo #(
    parameter int W = 18,
    parameter int D = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire wr = in_valid & in_ready;
    wire rd = out_valid & out_ready;

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clk_sys) begin
        if (wr) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (wr) begin
                wp_q <= (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
            end
            if (rd) begin
                rp_q <= (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;
            end
            if (wr && !rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (rd && !wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : adr_fifo

module adr_serial_readout
    import adr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic shift_clk,
    input wire logic convert_start_a,
    input wire logic convert_start_b,
    input wire logic interface_select,
    input wire logic byte_serial_select,
    input wire logic [OSR_W-1:0] oversample_ratio_pins,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] sample_data,
    output logic sample_ready,
    output logic serial_out_a,
    output logic serial_out_b,
    output logic first_channel_flag,
    output logic serial_oe_n,
    output logic busy,
    output logic [OSR_W-1:0] oversampling_ratio
);
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [1:0] lvl3_q;
    logic [4:0] bit_q;
    logic [2:0] grp_q;
    logic hold_q;
    logic flag_q;
    logic oe_n_q;
    logic out_a_q;
    logic out_b_q;
    adr_conv_t state_q;
    logic [2:0] ch_q;
    logic [5:0] pass_q;
    logic busy_q;
    logic conv_lvl_q;
    logic [OSR_W-1:0] osr_q;
    logic [9:0] busy_cnt_q;
    logic signed [ACC_W-1:0] acc_q [CH_N];
    logic [RES_W-1:0] bank_q [CH_N];
    logic f_valid;
    logic [RES_W-1:0] f_data;

    // Pins pass two flops; edges compare stage two against stage three
    wire [SYNC_W-1:0] pin_raw = {chip_select_n, shift_clk, convert_start_a, convert_start_b,
                                 interface_select, byte_serial_select, oversample_ratio_pins};
    wire cs_s = sync2_q[PIN_CS];
    wire sclk_s = sync2_q[PIN_SCLK];
    wire serial_mode = sync2_q[PIN_IFS] & ~sync2_q[PIN_BSS];
    wire active = ~cs_s & serial_mode;
    wire cs_fall = lvl3_q[1] & active;
    wire cs_rise = cs_s & ~lvl3_q[1] & serial_mode;
    wire sclk_rise = sclk_s & ~lvl3_q[0] & active;
    wire sclk_fall = ~sclk_s & lvl3_q[0] & active;
    wire last_bit = bit_q == BIT_LAST;
    wire [2:0] grp_next = grp_q + 3'h1;
    wire load_evt = state_q == ADR_LOAD;
    wire [OSR_W-1:0] osr_eff = (osr_q > OSR_W'(OSR_MAX)) ? OSR_RST : osr_q;
    wire [5:0] pass_last = 6'((7'h01 << osr_eff) - 7'h01);
    // Oversampling only starts when both start inputs are high
    wire conv_lvl = (osr_q != OSR_RST) ? (sync2_q[PIN_CVA] & sync2_q[PIN_CVB]) : sync2_q[PIN_CVA];
    wire conv_start = conv_lvl & ~conv_lvl_q & (state_q == ADR_IDLE);
    wire f_ready = state_q == ADR_RUN;
    wire take = f_valid & f_ready;
    wire signed [ACC_W-1:0] sext = {{OSR_MAX{f_data[RES_W-1]}}, f_data};
    wire sel_a = bit_of(bank_q[grp_q], bit_q);
    wire sel_b = bit_of(bank_q[grp_q ^ B_OFFSET], bit_q);

    assign serial_out_a = out_a_q;
    assign serial_out_b = out_b_q;
    assign first_channel_flag = flag_q;
    assign serial_oe_n = oe_n_q;
    assign busy = busy_q;
    assign oversampling_ratio = osr_q;

    adr_fifo #(.W(RES_W), .D(FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .in_ready(sample_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_ready)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            lvl3_q <= 2'h2;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            lvl3_q <= sync2_q[PIN_CS:PIN_SCLK];
        end
    end

    // Readout pointer; reading never looks at busy, so it works mid-conversion
    always_ff @(posedge clk_sys) begin
        if (rst || !serial_mode) begin
            bit_q <= BIT_FIRST;
            grp_q <= GRP_FIRST;
            hold_q <= 1'b0;
            flag_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (load_evt) begin
            // A select release on the load cycle must still float the lines
            oe_n_q <= oe_n_q | cs_s;
            bit_q <= BIT_FIRST;
            grp_q <= GRP_FIRST;
            hold_q <= 1'b0;
            flag_q <= 1'b0;
        end else if (cs_s) begin
            oe_n_q <= 1'b1;
            flag_q <= 1'b0;
        end else if (cs_fall) begin
            oe_n_q <= 1'b0;
            bit_q <= BIT_FIRST;
            hold_q <= 1'b0;
            flag_q <= grp_q == GRP_FIRST;
        end else if (sclk_fall && last_bit && !hold_q) begin
            // Advance at the 18th fall; next rise must not skip the new MSB
            grp_q <= grp_next;
            bit_q <= BIT_FIRST;
            hold_q <= 1'b1;
            flag_q <= grp_next == GRP_FIRST;
        end else if (sclk_rise) begin
            hold_q <= 1'b0;
            if (!hold_q && !last_bit) begin
                bit_q <= bit_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            out_a_q <= sel_a;
            out_b_q <= sel_b;
        end
    end

    // Conversion: 2^ratio passes of eight channels for ratios 0-6, one pass for 7, so busy grows up to ratio 6
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ADR_IDLE;
            ch_q <= 3'h0;
            pass_q <= 6'h00;
            busy_q <= 1'b0;
            conv_lvl_q <= 1'b0;
            osr_q <= OSR_RST;
            busy_cnt_q <= BUSY_CNT_RST;
        end else begin
            conv_lvl_q <= conv_lvl;
            case (state_q)
                ADR_IDLE: begin
                    if (conv_start) begin
                        state_q <= ADR_RUN;
                        ch_q <= 3'h0;
                        pass_q <= 6'h00;
                        busy_q <= 1'b1;
                        busy_cnt_q <= BUSY_CNT_RST;
                    end
                end
                ADR_RUN: begin
                    // Saturates so a slow sample stream cannot wrap the length count
                    if (busy_cnt_q != 10'h3ff) begin
                        busy_cnt_q <= busy_cnt_q + 10'h001;
                    end
                    if (take) begin
                        ch_q <= ch_q + 3'h1;
                        if (ch_q == CH_LAST) begin
                            pass_q <= pass_q + 6'h01;
                            if (pass_q == pass_last) begin
                                state_q <= ADR_LOAD;
                            end
                        end
                    end
                end
                ADR_LOAD: begin
                    // Bank and busy change on the same edge; host must be idle here
                    state_q <= ADR_IDLE;
                    busy_q <= 1'b0;
                    osr_q <= sync2_q[OSR_W-1:0];
                end
                default: begin
                    state_q <= ADR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < CH_N; i++) begin
                acc_q[i] <= '0;
                bank_q[i] <= RES_RST;
            end
        end else begin
            if (take) begin
                acc_q[ch_q] <= (pass_q == 6'h00) ? sext : acc_q[ch_q] + sext;
            end
            if (load_evt) begin
                for (int i = 0; i < CH_N; i++) begin
                    bank_q[i] <= avg_of(acc_q[i], osr_eff);
                end
            end
        end
    end

    chk_mode_gate_off: assert property (@(posedge clk_sys) disable iff (rst)
        !serial_mode |=> serial_oe_n) else $error("outputs driven outside serial mode");
    chk_idle_hiz: assert property (@(posedge clk_sys) disable iff (rst)
        cs_s |=> serial_oe_n && !first_channel_flag) else $error("outputs active while deselected");
    chk_msb_first: assert property (@(posedge clk_sys) disable iff (rst)
        cs_fall && !load_evt |=> !serial_oe_n ##1 serial_out_a == bank_q[grp_q][RES_W-1])
        else $error("line A did not present MSB after select fall");
    chk_bit_step: assert property (@(posedge clk_sys) disable iff (rst)
        sclk_rise && !hold_q && !last_bit && !load_evt |=> bit_q == $past(bit_q) + 5'h01)
        else $error("bit position did not advance on rising edge");
    chk_b_order: assert property (@(posedge clk_sys) disable iff (rst)
        cs_fall && grp_q == GRP_FIRST && !load_evt |=> ##1 serial_out_b == bank_q[B_OFFSET][RES_W-1])
        else $error("line B did not start with channel 5");
    chk_flag_drop: assert property (@(posedge clk_sys) disable iff (rst)
        sclk_fall && last_bit && !hold_q && grp_q != CH_LAST && !load_evt |=> !first_channel_flag)
        else $error("flag not cleared at 18th falling edge");
    chk_flag_grp: assert property (@(posedge clk_sys) disable iff (rst)
        first_channel_flag |-> grp_q == GRP_FIRST) else $error("flag high outside first group");
    chk_prev_hold: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ADR_RUN |=> $stable(bank_q[0])) else $error("bank changed during conversion");
    chk_osr_latch: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(busy) |-> oversampling_ratio == $past(sync2_q[OSR_W-1:0]))
        else $error("ratio not latched at busy fall");
    chk_busy_len: assert property (@(posedge clk_sys) disable iff (rst)
        load_evt |-> busy_cnt_q >= (10'(CH_N) << osr_eff)) else $error("busy shorter than ratio needs");
    chk_avg_load: assert property (@(posedge clk_sys) disable iff (rst)
        load_evt && busy |=> !busy && bank_q[1] == avg_of($past(acc_q[1]), $past(osr_eff)))
        else $error("bank not loaded with average at busy fall");
    chk_pos_kept: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise && !load_evt |=> grp_q == $past(grp_q)) else $error("channel position lost on release");

    cov_frame_start: cover property (@(posedge clk_sys) disable iff (rst) cs_fall);
    cov_last_group: cover property (@(posedge clk_sys) disable iff (rst) sclk_fall && last_bit && grp_q == CH_LAST);
    cov_busy_fall: cover property (@(posedge clk_sys) disable iff (rst) $fell(busy));
    cov_read_busy: cover property (@(posedge clk_sys) disable iff (rst) busy && sclk_rise);
endmodule : adr_serial_readout

// [sim/adr_host_model.sv]
// Purpose: Host that clocks results out of both serial lines
// Assumes: Shift clock idles high between frames, 64 ns period
// Notes: Samples on falling edges, as a real host does
`timescale 1ns/1ps
module adr_host_model (
    output logic chip_select_n,
    output logic shift_clk,
    input wire logic serial_out_a,
    input wire logic serial_out_b,
    input wire logic first_channel_flag,
    input wire logic serial_oe_n
);
    logic [17:0] got_a [8];
    logic [17:0] got_b [8];
    logic [17:0] got_f [8];
    int oe_bad = 0;
    initial begin
        chip_select_n = 1'b1;
        shift_clk = 1'b1;
    end
    task automatic read(input int n, input bit framed);
        for (int g = 0; g < n; g++) begin
            if (framed || g == 0) begin
                chip_select_n = 1'b0;
                #64;
            end
            for (int i = 17; i >= 0; i--) begin
                shift_clk = 1'b0;
                got_a[g][i] = serial_out_a;
                got_b[g][i] = serial_out_b;
                got_f[g][i] = first_channel_flag;
                if (serial_oe_n !== 1'b0) begin
                    oe_bad++;
                end
                #32;
                shift_clk = 1'b1;
                #32;
            end
            if (framed || g == n - 1) begin
                chip_select_n = 1'b1;
                #64;
            end
        end
    endtask : read
    task automatic idle(input int n);
        repeat (n) begin
            shift_clk = 1'b0;
            #32;
            shift_clk = 1'b1;
            #32;
        end
    endtask : idle
    task automatic sel_pulse(output logic oe);
        chip_select_n = 1'b0;
        #100;
        oe = serial_oe_n;
        chip_select_n = 1'b1;
        #64;
    endtask : sel_pulse
endmodule : adr_host_model

// [sim/adr_serial_readout_bench.sv]
// Purpose: Self-checking bench for the serial readout block
// Assumes: Host model drives select and shift clock
// Notes: Ratio 2 conversion checks averaging and read during busy
`timescale 1ns/1ps
module adr_serial_readout_bench
    import adr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic chip_select_n;
    logic shift_clk;
    logic convert_start_a = 1'b0;
    logic convert_start_b = 1'b0;
    logic interface_select = 1'b1;
    logic byte_serial_select = 1'b0;
    logic [OSR_W-1:0] oversample_ratio_pins = 3'h0;
    logic sample_valid = 1'b0;
    logic [RES_W-1:0] sample_data = 18'h0_0000;
    logic sample_ready;
    logic serial_out_a;
    logic serial_out_b;
    logic first_channel_flag;
    logic serial_oe_n;
    logic busy;
    logic [OSR_W-1:0] oversampling_ratio;
    int err_total = 0;
    int samples_checked = 0;
    int busy_cyc = 0;
    logic [RES_W-1:0] v1 [CH_N];
    logic [RES_W-1:0] v2 [CH_N];
    logic [RES_W-1:0] v3 [CH_N];

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (busy === 1'b1) begin
            busy_cyc = busy_cyc + 1;
        end
    end

    adr_serial_readout u_adr_serial_readout (.clk_sys(clk_sys), .rst(rst), .chip_select_n(chip_select_n),
        .shift_clk(shift_clk), .convert_start_a(convert_start_a), .convert_start_b(convert_start_b),
        .interface_select(interface_select), .byte_serial_select(byte_serial_select),
        .oversample_ratio_pins(oversample_ratio_pins), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_ready(sample_ready), .serial_out_a(serial_out_a), .serial_out_b(serial_out_b),
        .first_channel_flag(first_channel_flag), .serial_oe_n(serial_oe_n), .busy(busy),
        .oversampling_ratio(oversampling_ratio));
    adr_host_model u_adr_host_model (.chip_select_n(chip_select_n), .shift_clk(shift_clk),
        .serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .first_channel_flag(first_channel_flag),
        .serial_oe_n(serial_oe_n));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic push(input logic [RES_W-1:0] w, input int gap);
        logic ok;
        // One edge always passes with valid low between two words
        repeat (gap + 1) @(posedge clk_sys);
        #1;
        sample_valid = 1'b1;
        sample_data = w;
        // Ready is judged at the falling edge so the taking edge is unambiguous
        do begin
            @(negedge clk_sys);
            ok = sample_ready;
            @(posedge clk_sys);
        end while (ok !== 1'b1);
        #1;
        sample_valid = 1'b0;
    endtask : push
    task automatic conv();
        busy_cyc = 0;
        tick();
        convert_start_a = 1'b1;
        convert_start_b = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        convert_start_a = 1'b0;
        convert_start_b = 1'b0;
    endtask : conv
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 4000) begin
            tick();
            n++;
        end
        chk("busy level", RES_W'(lvl), RES_W'(busy));
    endtask : wait_busy
    task automatic rd_chk(input int n, input bit framed, input logic [RES_W-1:0] ex [CH_N]);
        u_adr_host_model.read(n, framed);
        for (int g = 0; g < n; g++) begin
            chk("line a", ex[g], u_adr_host_model.got_a[g]);
            chk("line b", ex[g ^ 4], u_adr_host_model.got_b[g]);
            chk("flag", (g == 0) ? 18'h3_FFFF : 18'h0_0000, u_adr_host_model.got_f[g]);
        end
    endtask : rd_chk

    task automatic t_reset();
        logic oe;
        chk("oe after reset", 1, RES_W'(serial_oe_n));
        chk("ratio after reset", 0, RES_W'(oversampling_ratio));
        chk("busy after reset", 0, RES_W'(busy));
        tick();
        byte_serial_select = 1'b1;
        u_adr_host_model.sel_pulse(oe);
        chk("oe in byte mode", 1, RES_W'(oe));
        tick();
        byte_serial_select = 1'b0;
        interface_select = 1'b0;
        u_adr_host_model.sel_pulse(oe);
        chk("oe in parallel mode", 1, RES_W'(oe));
        tick();
        interface_select = 1'b1;
    endtask : t_reset
    task automatic t_full();
        oversample_ratio_pins = 3'h2;
        for (int c = 0; c < CH_N; c++) begin
            push(v1[c], 0);
        end
        chk("full fifo refuses", 0, RES_W'(sample_ready));
        conv();
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk("busy length", 1, RES_W'(busy_cyc >= 8));
        chk("ratio latched", 2, RES_W'(oversampling_ratio));
        rd_chk(8, 1'b0, v1);
    endtask : t_full
    task automatic t_framed();
        u_adr_host_model.idle(5);
        rd_chk(8, 1'b1, v1);
        chk("oe released", 1, RES_W'(serial_oe_n));
    endtask : t_framed
    task automatic t_osr();
        conv();
        wait_busy(1'b1);
        fork
            begin
                for (int p = 0; p < 4; p++) begin
                    for (int c = 0; c < CH_N; c++) begin
                        push(RES_W'(v2[c] + p), 16);
                    end
                end
            end
            begin
                rd_chk(1, 1'b1, v1);
                chk("read ends in busy", 1, RES_W'(busy));
            end
        join
        wait_busy(1'b0);
        chk("busy length", 1, RES_W'(busy_cyc >= 32));
        rd_chk(1, 1'b1, v3);
    endtask : t_osr

    initial begin
        for (int c = 0; c < CH_N; c++) begin
            v1[c] = RES_W'(18'h2_A5C3 + c * 18'h0_1111);
            v2[c] = RES_W'(18'h3_FF00 + c * 18'h0_0101);
            v3[c] = RES_W'(v2[c] + 1);
        end
        repeat (10) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (4) tick();
        t_reset();
        t_full();
        t_framed();
        t_osr();
        chk("oe low at samples", 0, RES_W'(u_adr_host_model.oe_bad));
        stop_test();
    end
    initial begin
        // The reads need about 22 us; over four times that marks a hang
        #100000;
        err_total++;
        $display("mismatch watchdog expected finish seen timeout");
        stop_test();
    end
endmodule : adr_serial_readout_bench
